/* verilog/cps_pkg.sv */
// Purpose: shared constants and types for the converter power sequencer
// Assumes: 250 MHz aclk, AXI4-Lite register access with 32-bit data
// Notes: times are kept in ns and turned into cycle counts here
package cps_pkg;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 4;
  localparam int BIAS_SETTLE_NS = 100000; // bias settle, 100 us
  localparam int SEL_SAMPLE_NS = 200000; // config resistor window, 200 us
  localparam int SOFTSTART_NS = 2000000; // soft-start, 2 ms
  localparam int HARDSHORT_NS = 427000; // current-limit timer trip, 427 us
  localparam int VCHG_STEP_NS = 1000; // base time per reference step
  // least times round up to whole cycles
  localparam int BIAS_SETTLE_CYC = (BIAS_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SEL_SAMPLE_CYC = (SEL_SAMPLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SOFTSTART_CYC = (SOFTSTART_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int HARDSHORT_CYC = (HARDSHORT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int VCHG_STEP_CYC = (VCHG_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TMR_W = 20; // wide enough for the soft-start count

  // ----------------------------------------------------------------
  // reference code, 4.5 V base in 73.5 mV steps up to 15 V
  // ----------------------------------------------------------------
  localparam int VREF_W = 8;
  localparam logic [7:0] VREF_CODE_MAX = 8'h8E; // 15 V
  localparam logic [7:0] VREF_RST = 8'h07; // about 5 V
  localparam int VREF_STEPS = 143; // soft-start steps from zero to max

  // ----------------------------------------------------------------
  // register map and fields
  // ----------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_FAULT = 8'h08;
  localparam int CTRL_VREF_LSB = 0;
  localparam int CTRL_SLEW_LSB = 8;
  localparam int CTRL_FREQ_LSB = 10;
  localparam int CTRL_ILIM_LSB = 12;
  localparam int CTRL_ILIM_OVR_BIT = 15;
  localparam logic [31:0] CTRL_RST = 32'h0000_0007;
  localparam logic [1:0] FREQ_1M8 = 2'h0;
  localparam logic [1:0] FREQ_1M5 = 2'h1;
  localparam logic [1:0] FREQ_1M2 = 2'h2;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------
  // config resistor code layout
  // ----------------------------------------------------------------
  localparam int SEL_W = 5;
  localparam int SEL_ADDR_LSB = 0;
  localparam int SEL_ILIM_LSB = 2;
  localparam int SEL_FB_BIT = 4;

  // sequencer states, gray along the startup path through ST_WAIT_DIS (ST_OFF to ST_SETTLE flips two bits)
  typedef enum logic [2:0] {
    ST_OFF = 3'h0,
    ST_WAIT_DIS = 3'h1,
    ST_SETTLE = 3'h3,
    ST_SAMPLE = 3'h2,
    ST_SERIAL = 3'h6,
    ST_SOFTSTART = 3'h7,
    ST_RUN = 3'h5,
    ST_LATCHED = 3'h4
  } cps_state_t;

endpackage

/* verilog/cps_timer.sv */
// Purpose: interval counter for the sequencer
// Assumes: restart is a one-cycle pulse from the same clock
// Notes: done rises once limit cycles of the interval have passed
`timescale 1ns/1ps
module cps_timer
  import cps_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic restart,
  input wire logic [cps_pkg::TMR_W-1:0] limit,
  output logic done
);
  import cps_pkg::*;

  logic [TMR_W-1:0] count_q; // cycles into the interval, restart cycle is the first

  // ----------------------------------------------------------------
  // count up and hold at the limit
  // ----------------------------------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn || restart)
    begin
      count_q <= (aresetn && restart) ? TMR_W'(1'b1) : '0;
    end
    else if (count_q < limit)
    begin
      count_q <= count_q + 1'b1;
    end
  end

  // limit reached
  assign done = (count_q >= limit);

endmodule

/* verilog/cps_sequencer.sv */
// Purpose: startup, shutdown and fault sequencing of a buck-boost converter
// Assumes: analog comparator levels arrive asynchronously on pins
// Notes: registers sit behind an AXI4-Lite slave that stands for the serial link
//
// The register offsets and the AXI4-Lite slave port are this design's own decisions.
`timescale 1ns/1ps
// Operation
// RULE1 - wait bias settle after enable
// RULE2 - discharge output during bias settle
// RULE3 - below 1.5V: discharge off, sample resistor
// RULE4 - sampling window lasts 200 us
// RULE5 - serial interface on, then soft-start
// RULE6 - earlier discharge running defers startup
// RULE7 - reference ramps to target over 2ms
// RULE8 - under 2V: 300kHz, reduced limit
// RULE9 - hard-short detection armed after soft-start
// RULE10 - enable low: stop, reset, discharge
// RULE11 - undervoltage: output, serial off, reset
// RULE12 - thermal or 427us limit: latch off
// RULE13 - host clears latch by power cycle
// RULE14 - fault discharge except thermal shutdown
// RULE15 - host settings override resistor decode
// RULE16 - decode address, limit, feedback choice
// RULE17 - slew, limit, frequency host choices
// RULE18 - reference 4.5V to 15V steps
// RULE19 - freeze power good during ramps
// RULE20 - sticky fault flags cleared by cycling
// RULE21 - intervals from counters on clock
module cps_sequencer
  import cps_pkg::*;
#(
  parameter int BIAS_SETTLE_CYCLES = cps_pkg::BIAS_SETTLE_CYC,
  parameter int SEL_SAMPLE_CYCLES = cps_pkg::SEL_SAMPLE_CYC,
  parameter int SOFTSTART_CYCLES = cps_pkg::SOFTSTART_CYC,
  parameter int HARDSHORT_CYCLES = cps_pkg::HARDSHORT_CYC
)
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic en_pin,
  input wire logic vin_ok,
  input wire logic vio_ok,
  input wire logic out_above_1v5,
  input wire logic out_above_2v,
  input wire logic thermal_fault,
  input wire logic ilim_active,
  input wire logic pg_raw,
  input wire logic [cps_pkg::SEL_W-1:0] sel_code,
  output logic bias_en,
  output logic discharge_en,
  output logic sel_sample_en,
  output logic serial_if_en,
  output logic switching_en,
  output logic low_freq_mode,
  output logic reduced_current_limit,
  output logic hardshort_armed,
  output logic [cps_pkg::VREF_W-1:0] vref_code,
  output logic [1:0] freq_sel,
  output logic [2:0] ilim_sel,
  output logic [1:0] slave_addr,
  output logic ext_feedback,
  output logic power_good_flag,
  output logic regs_in_reset,
  input wire logic [cps_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [cps_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  import cps_pkg::*;

  localparam int NPIN = 8 + SEL_W; // synchronised pin count
  localparam int SS_STEP_CYC = SOFTSTART_CYCLES / VREF_STEPS; // soft-start step time

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [NPIN-1:0] pin_raw; // raw pin vector
  logic [NPIN-1:0] sync1_q; // first stage, read only by second
  logic [NPIN-1:0] sync2_q; // safe copy
  logic en_s, vin_s, vio_s, hi1v5_s, hi2v_s, therm_s, ilim_s, pg_s;
  logic [SEL_W-1:0] sel_s;

  assign pin_raw = {sel_code, pg_raw, ilim_active, thermal_fault, out_above_2v,
                    out_above_1v5, vio_ok, vin_ok, en_pin};

  genvar gi;
  generate
    for (gi = 0; gi < NPIN; gi++)
    begin : g_sync
      // two flops per pin
      always_ff @(posedge aclk)
      begin
        if (!aresetn)
        begin
          sync1_q[gi] <= 1'b0;
          sync2_q[gi] <= 1'b0;
        end
        else
        begin
          sync1_q[gi] <= pin_raw[gi];
          sync2_q[gi] <= sync1_q[gi];
        end
      end
    end
  endgenerate

  assign {sel_s, pg_s, ilim_s, therm_s, hi2v_s, hi1v5_s, vio_s, vin_s, en_s} = sync2_q;

  // ----------------------------------------------------------------
  // state and shared interval timer
  // ----------------------------------------------------------------
  cps_state_t state_q, state_d;
  logic supply_lockout; // either supply invalid
  logic regs_rst; // register reset condition
  logic tmr_done; // interval expired
  logic [TMR_W-1:0] tmr_limit; // interval for the state being entered
  logic hs_trip; // hard-short timer tripped
  logic thermal_latched_q; // latch came from thermal shutdown

  assign supply_lockout = !vin_s || !vio_s;
  // RULE10 enable low resets
  // RULE11 undervoltage resets
  assign regs_rst = !aresetn || !en_s || supply_lockout;

  // RULE21 interval terminal counts
  always_comb
  begin
    case (state_d)
      ST_SETTLE: tmr_limit = TMR_W'(BIAS_SETTLE_CYCLES);
      ST_SAMPLE: tmr_limit = TMR_W'(SEL_SAMPLE_CYCLES);
      ST_SOFTSTART: tmr_limit = TMR_W'(SOFTSTART_CYCLES);
      default: tmr_limit = '0;
    endcase
  end

  logic [TMR_W-1:0] tmr_limit_q; // held limit for the running interval
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      tmr_limit_q <= '0;
    else if (state_d != state_q)
      tmr_limit_q <= tmr_limit;
  end

  cps_timer cps_timer_i (
    .aclk(aclk),
    .aresetn(aresetn),
    .restart(state_d != state_q),
    .limit(tmr_limit_q),
    .done(tmr_done)
  );

  // next state
  always_comb
  begin
    state_d = state_q;
    case (state_q)
      // RULE6 wait out earlier discharge
      ST_OFF: if (en_s && !supply_lockout) state_d = hi1v5_s ? ST_WAIT_DIS : ST_SETTLE;
      ST_WAIT_DIS: if (!hi1v5_s) state_d = ST_SETTLE;
      // RULE1 bias settle wait
      // RULE3 exit below 1.5V
      ST_SETTLE: if (tmr_done && !hi1v5_s) state_d = ST_SAMPLE;
      // RULE4 sampling window
      ST_SAMPLE: if (tmr_done) state_d = ST_SERIAL;
      // RULE5 serial then soft-start
      ST_SERIAL: state_d = ST_SOFTSTART;
      // RULE9 arm after timer
      ST_SOFTSTART: if (tmr_done) state_d = ST_RUN;
      ST_RUN: state_d = ST_RUN;
      ST_LATCHED: state_d = ST_LATCHED;
      default: state_d = ST_OFF;
    endcase
    // RULE12 latch-off faults
    if ((state_q == ST_SOFTSTART || state_q == ST_RUN) && (therm_s || hs_trip))
      state_d = ST_LATCHED;
    // RULE10 enable low shutdown
    // RULE13 power cycle clears latch
    if (!en_s || supply_lockout)
      state_d = ST_OFF;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      state_q <= ST_OFF;
    else
      state_q <= state_d;
  end

  // remember the thermal cause of a latch
  always_ff @(posedge aclk)
  begin
    if (regs_rst)
      thermal_latched_q <= 1'b0;
    else if (state_q != ST_LATCHED && state_d == ST_LATCHED)
      thermal_latched_q <= therm_s;
  end

  // ----------------------------------------------------------------
  // hard-short current-limit timer
  // ----------------------------------------------------------------
  logic [TMR_W-1:0] hs_cnt_q; // cycles in current limit
  always_ff @(posedge aclk)
  begin
    if (!aresetn || !hardshort_armed || !ilim_s)
      hs_cnt_q <= '0;
    else if (!hs_trip)
      hs_cnt_q <= hs_cnt_q + 1'b1;
  end
  // RULE12 427us limit trip
  assign hs_trip = (hs_cnt_q >= TMR_W'(HARDSHORT_CYCLES));

  // ----------------------------------------------------------------
  // sampled resistor configuration
  // ----------------------------------------------------------------
  logic [SEL_W-1:0] sel_q; // decoded resistor code
  always_ff @(posedge aclk)
  begin
    if (regs_rst)
      sel_q <= '0;
    // RULE16 latch decode at window end
    else if (state_q == ST_SAMPLE && tmr_done)
      sel_q <= sel_s;
  end

  // ----------------------------------------------------------------
  // host control register
  // ----------------------------------------------------------------
  logic [31:0] ctrl_q; // host settings
  logic wr_fire; // write performed this cycle
  logic [ADDR_W-1:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic [31:0] ctrl_d;
  logic [7:0] vref_tgt;
  logic [1:0] slew;

  // byte-lane merge and range checks
  always_comb
  begin
    ctrl_d = ctrl_q;
    for (int b = 0; b < 4; b++)
      if (wstrb_q[b])
        ctrl_d[b*8 +: 8] = wdata_q[b*8 +: 8];
    // RULE18 clamp to 15V code
    if (ctrl_d[CTRL_VREF_LSB +: VREF_W] > VREF_CODE_MAX)
      ctrl_d[CTRL_VREF_LSB +: VREF_W] = VREF_CODE_MAX;
    // RULE17 three frequency codes
    if (ctrl_d[CTRL_FREQ_LSB +: 2] != FREQ_1M8 && ctrl_d[CTRL_FREQ_LSB +: 2] != FREQ_1M5
        && ctrl_d[CTRL_FREQ_LSB +: 2] != FREQ_1M2)
      ctrl_d[CTRL_FREQ_LSB +: 2] = ctrl_q[CTRL_FREQ_LSB +: 2];
  end

  // RULE11 registers held in reset
  always_ff @(posedge aclk)
  begin
    if (regs_rst)
      ctrl_q <= CTRL_RST;
    else if (wr_fire && awaddr_q == REG_CTRL && serial_if_en)
      ctrl_q <= ctrl_d;
  end

  assign vref_tgt = ctrl_q[CTRL_VREF_LSB +: VREF_W];
  assign slew = ctrl_q[CTRL_SLEW_LSB +: 2];

  // ----------------------------------------------------------------
  // reference ramp for soft-start and voltage changes
  // ----------------------------------------------------------------
  logic [VREF_W-1:0] vref_q; // live reference code
  logic [TMR_W-1:0] step_cnt_q; // cycles since last step
  logic [TMR_W-1:0] step_len; // step time for the ramp
  logic ramping; // ramp in progress

  assign step_len = (state_q == ST_SOFTSTART) ? TMR_W'(SS_STEP_CYC) : (TMR_W'(VCHG_STEP_CYC) << slew);
  assign ramping = (state_q == ST_SOFTSTART) || (state_q == ST_RUN && vref_q != vref_tgt);

  always_ff @(posedge aclk)
  begin
    if (regs_rst || !ramping || step_cnt_q >= step_len)
      step_cnt_q <= '0;
    else
      step_cnt_q <= step_cnt_q + 1'b1;
  end

  // RULE7 gradual ramp to target
  always_ff @(posedge aclk)
  begin
    if (regs_rst || state_q == ST_OFF || state_q == ST_LATCHED)
      vref_q <= '0;
    else if (state_q == ST_SOFTSTART && tmr_done)
      vref_q <= vref_tgt;
    else if (ramping && step_cnt_q >= step_len)
    begin
      if (vref_q < vref_tgt)
        vref_q <= vref_q + 1'b1;
      else if (vref_q > vref_tgt)
        vref_q <= vref_q - 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // power good and sticky fault flags
  // ----------------------------------------------------------------
  logic pg_q; // held power good
  logic flag_therm_q, flag_hs_q; // sticky faults

  // RULE19 hold value while ramping
  always_ff @(posedge aclk)
  begin
    if (regs_rst)
      pg_q <= 1'b0;
    else if (state_q == ST_RUN && !ramping)
      pg_q <= pg_s;
  end

  // RULE20 sticky until power cycle
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      flag_therm_q <= 1'b0;
      flag_hs_q <= 1'b0;
    end
    else
    begin
      if (therm_s && state_q != ST_OFF)
        flag_therm_q <= 1'b1;
      else if (regs_rst)
        flag_therm_q <= 1'b0;
      if (hs_trip)
        flag_hs_q <= 1'b1;
      else if (regs_rst)
        flag_hs_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // control outputs
  // ----------------------------------------------------------------
  // RULE1 bias on from settle, off while waiting out an earlier discharge
  assign bias_en = (state_q != ST_OFF) && (state_q != ST_WAIT_DIS);
  // RULE2 discharge while settling
  // RULE14 no discharge on thermal
  assign discharge_en = (state_q == ST_OFF) || (state_q == ST_WAIT_DIS) || (state_q == ST_SETTLE)
                        || (state_q == ST_LATCHED && !thermal_latched_q);
  assign sel_sample_en = (state_q == ST_SAMPLE);
  // RULE5 serial active from here
  // RULE12 serial kept during latch
  assign serial_if_en = (state_q == ST_SERIAL) || (state_q == ST_SOFTSTART)
                        || (state_q == ST_RUN) || (state_q == ST_LATCHED);
  assign switching_en = (state_q == ST_SOFTSTART) || (state_q == ST_RUN);
  // RULE8 low-voltage foldback
  assign low_freq_mode = switching_en && !hi2v_s;
  assign reduced_current_limit = switching_en && !hi2v_s;
  // RULE9 armed only after soft-start
  assign hardshort_armed = (state_q == ST_RUN);
  assign vref_code = vref_q;
  assign freq_sel = ctrl_q[CTRL_FREQ_LSB +: 2];
  // RULE15 host limit overrides decode
  assign ilim_sel = ctrl_q[CTRL_ILIM_OVR_BIT] ? ctrl_q[CTRL_ILIM_LSB +: 3] : {1'b0, sel_q[SEL_ILIM_LSB +: 2]};
  assign slave_addr = sel_q[SEL_ADDR_LSB +: 2];
  assign ext_feedback = sel_q[SEL_FB_BIT];
  assign power_good_flag = pg_q;
  assign regs_in_reset = regs_rst;

  // ----------------------------------------------------------------
  // axi4-lite slave
  // ----------------------------------------------------------------
  logic aw_have_q, w_have_q, bvalid_q, rvalid_q;
  logic [1:0] bresp_q, rresp_q;
  logic [31:0] rdata_q;

  assign s_axi_awready = !aw_have_q && !bvalid_q;
  assign s_axi_wready = !w_have_q && !bvalid_q;
  assign wr_fire = aw_have_q && w_have_q && !bvalid_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = !rvalid_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;

  // write address and data capture, response
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
      awaddr_q <= '0;
      wdata_q <= '0;
      wstrb_q <= '0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_have_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_have_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (wr_fire)
      begin
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
        bvalid_q <= 1'b1;
        // writes refused while the serial side is off
        bresp_q <= (awaddr_q == REG_CTRL && serial_if_en) ? RESP_OKAY : RESP_SLVERR;
      end
      else if (bvalid_q && s_axi_bready)
        bvalid_q <= 1'b0;
    end
  end

  // read decode and response
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid_q <= 1'b0;
      rdata_q <= '0;
      rresp_q <= RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      rvalid_q <= 1'b1;
      rresp_q <= RESP_OKAY;
      case (s_axi_araddr)
        REG_CTRL: rdata_q <= ctrl_q;
        // state, power good, serial, ramp, feedback, address, decoded limit
        REG_STATUS: rdata_q <= {20'h0_0000, sel_q[SEL_ILIM_LSB +: 2], slave_addr, ext_feedback,
                                ramping, serial_if_en, pg_q, 1'b0, state_q};
        REG_FAULT: rdata_q <= {30'h0000_0000, flag_hs_q, flag_therm_q};
        default:
        begin
          rdata_q <= '0;
          rresp_q <= RESP_SLVERR;
        end
      endcase
    end
    else if (rvalid_q && s_axi_rready)
      rvalid_q <= 1'b0;
  end

endmodule

/* verification/cps_sequencer_chk.sv */
// Purpose: port checker for the power sequencer
// Assumes: bench shortens the intervals by parameter
// Notes: bind statement at the foot
`timescale 1ns/1ps
module cps_sequencer_chk #(
  parameter int SEL_SAMPLE_CYCLES = 20,
  parameter int SOFTSTART_CYCLES = 300
)
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic en_pin,
  input wire logic vin_ok,
  input wire logic thermal_fault,
  input wire logic out_above_1v5,
  input wire logic bias_en,
  input wire logic discharge_en,
  input wire logic sel_sample_en,
  input wire logic serial_if_en,
  input wire logic switching_en,
  input wire logic low_freq_mode,
  input wire logic reduced_current_limit,
  input wire logic hardshort_armed,
  input wire logic regs_in_reset
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  int n_smp;
  int n_ss;
  // length of the sampling window and of the ramp
  always_ff @(posedge aclk)
    n_smp <= (!aresetn || !sel_sample_en) ? 0 : n_smp + 1;
  always_ff @(posedge aclk)
    n_ss <= (!aresetn || !switching_en || hardshort_armed) ? 0 : n_ss + 1;
  property p_bias;
    $rose(bias_en) |-> discharge_en;
  endproperty
  a_bias: assert property (p_bias) else $error("discharge off in settle");
  property p_smp;
    sel_sample_en |-> !discharge_en && !out_above_1v5;
  endproperty
  a_smp: assert property (p_smp) else $error("sampling while discharging");
  property p_smp_len;
    $fell(sel_sample_en) && !regs_in_reset |-> n_smp == SEL_SAMPLE_CYCLES;
  endproperty
  a_smp_len: assert property (p_smp_len) else $error("sample window length");
  property p_order;
    $rose(switching_en) |-> $past(serial_if_en);
  endproperty
  a_order: assert property (p_order) else $error("ramp before serial");
  property p_ss_len;
    $rose(hardshort_armed) |-> n_ss == SOFTSTART_CYCLES;
  endproperty
  a_ss_len: assert property (p_ss_len) else $error("soft-start length");
  property p_fold;
    low_freq_mode |-> switching_en && reduced_current_limit;
  endproperty
  a_fold: assert property (p_fold) else $error("foldback mismatch");
  property p_off;
    $fell(en_pin) |-> ##[1:4] (!switching_en && discharge_en && regs_in_reset);
  endproperty
  a_off: assert property (p_off) else $error("no shutdown on enable low");
  property p_uv;
    $fell(vin_ok) |-> ##[1:4] (!serial_if_en && !switching_en && regs_in_reset);
  endproperty
  a_uv: assert property (p_uv) else $error("no lockout on supply loss");
  property p_therm;
    $rose(thermal_fault) && switching_en && en_pin && vin_ok |-> ##[1:4] (!switching_en && !discharge_en);
  endproperty
  a_therm: assert property (p_therm) else $error("thermal latch wrong");
  c_run: cover property ($rose(hardshort_armed));
  c_smp: cover property ($fell(sel_sample_en));
  c_therm: cover property ($rose(thermal_fault) && switching_en);
endmodule
bind cps_sequencer cps_sequencer_chk #(.SEL_SAMPLE_CYCLES(SEL_SAMPLE_CYCLES),
  .SOFTSTART_CYCLES(SOFTSTART_CYCLES)) cps_sequencer_chk_i (.aclk(aclk), .aresetn(aresetn),
  .en_pin(en_pin), .vin_ok(vin_ok), .thermal_fault(thermal_fault), .out_above_1v5(out_above_1v5),
  .bias_en(bias_en), .discharge_en(discharge_en), .sel_sample_en(sel_sample_en),
  .serial_if_en(serial_if_en), .switching_en(switching_en), .low_freq_mode(low_freq_mode),
  .reduced_current_limit(reduced_current_limit), .hardshort_armed(hardshort_armed),
  .regs_in_reset(regs_in_reset));

/* verification/cps_out_model.sv */
// Purpose: crude model of the converter output level
// Assumes: one step per clock
// Notes: precharge pulse makes a pre-biased output
`timescale 1ns/1ps
module cps_out_model
(
  input wire logic aclk,
  input wire logic precharge,
  input wire logic switching_en,
  input wire logic discharge_en,
  output logic out_above_1v5,
  output logic out_above_2v
);
  logic [4:0] lvl_q = 5'h00;
  // rises while switching, drains while discharging
  always_ff @(posedge aclk)
  begin
    if (precharge)
      lvl_q <= 5'h1F;
    else if (switching_en && lvl_q != 5'h1F)
      lvl_q <= lvl_q + 5'h01;
    else if (discharge_en && lvl_q != 5'h00)
      lvl_q <= lvl_q - 5'h01;
  end
  assign out_above_1v5 = (lvl_q >= 5'h08);
  assign out_above_2v = (lvl_q >= 5'h0C);
endmodule

/* verification/converter_power_sequencer_bench.sv */
// Purpose: self-checking bench for the power sequencer
// Assumes: shortened intervals, AXI4-Lite master tasks
// Notes: reads sample values as they stood before each edge
`timescale 1ns/1ps
module converter_power_sequencer_bench;
  import cps_pkg::*;
  logic aclk = 0, aresetn = 0, en_pin = 0, vin_ok = 1, vio_ok = 1;
  logic thermal_fault = 0, ilim_active = 0, pg_raw = 1, pre = 0;
  logic out_above_1v5, out_above_2v;
  logic [4:0] sel_code = 5'h19;
  logic bias_en, discharge_en, sel_sample_en, serial_if_en, switching_en, low_freq_mode;
  logic reduced_current_limit, hardshort_armed, ext_feedback, power_good_flag, regs_in_reset;
  logic [7:0] vref_code, s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [1:0] freq_sel, slave_addr, s_axi_bresp, s_axi_rresp, rsp;
  logic [2:0] ilim_sel;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata, rdat;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  int n_errors = 0, cmp_count = 0, k;
  cps_sequencer #(.BIAS_SETTLE_CYCLES(20), .SEL_SAMPLE_CYCLES(20), .SOFTSTART_CYCLES(300),
    .HARDSHORT_CYCLES(30)) cps_sequencer_i (.*);
  cps_out_model cps_out_model_i (.aclk(aclk), .precharge(pre), .switching_en(switching_en),
    .discharge_en(discharge_en), .out_above_1v5(out_above_1v5), .out_above_2v(out_above_2v));
  initial forever #2 aclk = ~aclk;
  task chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      n_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task summarize;
    if (n_errors == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // bus write: both halves offered together, bready held until bvalid
  task wr(input logic [7:0] a, input logic [31:0] d);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    rsp = s_axi_bresp;
    s_axi_bready <= 1'b0;
    @(posedge aclk);
  endtask
  task rd(input logic [7:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    rdat = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge aclk);
  endtask
  task t_reset;
    chk(discharge_en, 1'b1);
    rd(REG_CTRL);
    chk(rdat, CTRL_RST);
    wr(REG_CTRL, 32'h0000_0020);
    chk(rsp, RESP_SLVERR);
  endtask
  // pre-biased start up to run
  task t_up;
    pre <= 1'b1;
    @(posedge aclk);
    pre <= 1'b0;
    en_pin <= 1'b1;
    repeat (300) if (!sel_sample_en) @(posedge aclk);
    chk(out_above_1v5, 1'b0);
    repeat (100) if (!switching_en) @(posedge aclk);
    chk(serial_if_en, 1'b1);
    chk(low_freq_mode, 1'b1);
    chk(power_good_flag, 1'b0);
    repeat (1000) if (!hardshort_armed) @(posedge aclk);
    chk(vref_code, VREF_RST);
    chk({ext_feedback, ilim_sel, slave_addr}, {1'b1, 3'h2, 2'h1});
    chk(low_freq_mode, 1'b0);
    repeat (6) @(posedge aclk);
    chk(power_good_flag, 1'b1);
    rd(REG_STATUS);
    chk(rdat, 32'h0000_09B5);
  endtask
  task t_regs;
    wr(REG_CTRL, 32'h0000_D8FF);
    rd(REG_CTRL);
    chk(rdat[7:0], VREF_CODE_MAX);
    for (int i = 0; i < 8; i++)
    begin
      wr(REG_CTRL, 32'h0000_8007 | (i << 12) | ((i % 4) << 10) | ((i % 4) << 8));
      chk(rsp, RESP_OKAY);
      chk(ilim_sel, i);
      chk(freq_sel, (i % 4 == 3) ? 2 : i % 4);
    end
    wr(8'h0C, 32'h0);
    chk(rsp, RESP_SLVERR);
  endtask
  task t_hs;
    ilim_active <= 1'b1;
    k = 0;
    while (switching_en && k < 100)
    begin
      @(posedge aclk);
      k++;
    end
    ilim_active <= 1'b0;
    chk(k >= 30 && k <= 35, 1'b1);
    chk(discharge_en, 1'b1);
    rd(REG_FAULT);
    chk({rsp, rdat}, {RESP_OKAY, 32'h2});
    rd(REG_CTRL);
    chk(rdat[14:12], 3'h7);
    repeat (40) @(posedge aclk);
    chk(switching_en, 1'b0);
    en_pin <= 1'b0;
    repeat (4) @(posedge aclk);
    rd(REG_FAULT);
    chk(rdat, 32'h0);
  endtask
  task t_th;
    t_up();
    thermal_fault <= 1'b1;
    repeat (8) @(posedge aclk);
    chk({switching_en, discharge_en}, 2'b00);
    rd(REG_FAULT);
    chk(rdat, 32'h1);
    thermal_fault <= 1'b0;
    en_pin <= 1'b0;
    repeat (4) @(posedge aclk);
  endtask
  task t_uv(input int j);
    t_up();
    wr(REG_CTRL, 32'h0000_0020);
    if (j == 0) vin_ok <= 1'b0;
    else vio_ok <= 1'b0;
    repeat (4) @(posedge aclk);
    chk({serial_if_en, regs_in_reset}, 2'b01);
    rd(REG_CTRL);
    chk(rdat, CTRL_RST);
    vin_ok <= 1'b1;
    vio_ok <= 1'b1;
    en_pin <= 1'b0;
    repeat (4) @(posedge aclk);
  endtask
  initial
  begin
    repeat (20000) @(posedge aclk);
    n_errors++;
    summarize();
  end
  initial
  begin
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_reset();
    t_up();
    t_regs();
    t_hs();
    t_th();
    t_uv(0);
    t_uv(1);
    summarize();
  end
endmodule
